// ---- rtl/sys_cal_pkg.sv ----
// Constants, types and register layout for the system calibration select and offset slice.
// Behaviour
// - Two calibration sets, selectable per result slot except slot 5, which has no field and always uses set A.
// - Selector 00 applies set A offset and gain.
// - Selector 01 applies set B offset and gain.
// - Selector 10 or 11 skips system correction.
// - Slot fields at fixed positions, gaps unused.
// - All selectors reset to 00.
// - Set A offset is two's complement always.
// - Offset writes persist until rewrite or calibration.
// - Offset after self-cal, before system gain.
// - Offset before unipolar/bipolar scale step.
// - Set A offset is 24-bit read/write.
// - Gain is unsigned 1.23 fixed point.
package sys_cal_pkg;

  // ----------------------------------------------------------------
  // Register map and field layout.
  // ----------------------------------------------------------------
  localparam logic [7:0]  CAL_SET_SELECT_ADDR  = 8'h12;    // Selector register address.
  localparam logic [7:0]  SYSTEM_OFFSET_A_ADDR = 8'h13;    // Set A offset register address.
  localparam logic [23:0] CAL_SET_SELECT_MASK  = 24'h00F3FF; // Bits that hold a slot field.
  localparam logic [23:0] CAL_SET_SELECT_RESET = 24'h000000; // All slots select set A.
  localparam logic [23:0] SYSTEM_OFFSET_RESET  = 24'h000000; // Offset value after reset.
  localparam int          SLOT_COUNT           = 8;         // Result slots.
  localparam int          GAIN_FRAC_BITS       = 23;        // Gain fraction bits below the unit bit.

  // ----------------------------------------------------------------
  // Selector encodings.
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_SET_A = 2'h0;  // Apply set A.
  localparam logic [1:0] SEL_SET_B = 2'h1;  // Apply set B.

  // Register bank state.
  typedef struct packed {
    logic [23:0] cal_set_select;   // Slot selector fields.
    logic [23:0] system_offset_a;  // Set A offset.
    logic [23:0] rd_data;          // Read data latch.
    logic [23:0] result;           // Corrected result.
    logic [2:0]  result_slot;      // Slot of the corrected result.
    logic        result_valid;     // Result strobe.
  } bank_state_t;

  // Incoming conversion request.
  typedef struct packed {
    logic        valid;      // Sample present.
    logic [2:0]  slot;       // Destination slot.
    logic        unipolar;   // Unipolar scale of two.
    logic [23:0] sample;     // Self-calibrated sample.
  } conv_in_t;

endpackage

// ---- rtl/system_cal_select_offset.sv ----
// Selector and set A offset registers with the system correction datapath.
module system_cal_select_offset (
  input  wire logic                  sys_clk_in,          // System clock, 10 MHz.
  input  wire logic                  reset_n_in,          // Asynchronous reset, active low.
  input  wire logic                  reg_wr_in,           // Register write strobe.
  input  wire logic                  reg_rd_in,           // Register read strobe.
  input  wire logic [7:0]            reg_addr_in,         // Register address.
  input  wire logic [23:0]           reg_wdata_in,        // Register write data.
  output logic      [23:0]           reg_rdata_out,       // Register read data.
  input  wire logic                  cal_load_a_in,       // System calibration writes set A offset.
  input  wire logic [23:0]           cal_offset_a_in,     // Offset measured by system calibration.
  input  wire logic [23:0]           system_offset_b_in,  // Set B offset from neighbour bank.
  input  wire logic [23:0]           system_gain_a_in,    // Set A gain, 1.23 unsigned.
  input  wire logic [23:0]           system_gain_b_in,    // Set B gain, 1.23 unsigned.
  input  wire sys_cal_pkg::conv_in_t conv_in,             // Self-calibrated conversion sample.
  output logic      [23:0]           result_out,          // Corrected result.
  output logic      [2:0]            result_slot_out,     // Destination slot of result.
  output logic                       result_valid_out,    // Result strobe, one cycle.
  output logic      [1:0]            slot_select_out      // Selector used for the current sample.
);

  // ----------------------------------------------------------------
  // Helper functions.
  // ----------------------------------------------------------------
  // Returns the two-bit selector for a slot; slot 5 has no field.
  // Slot 5 falls back to set A so that a stray sample still gets a defined correction.
  // The field of slot n sits at bit 2n, which keeps the decode to one indexed slice.
  function automatic logic [1:0] slot_sel(input logic [23:0] reg_v, input logic [2:0] slot);
    logic [4:0] pos;
    pos = {slot, 1'b0};
    slot_sel = (slot == 3'h5) ? sys_cal_pkg::SEL_SET_A : reg_v[pos +: 2];
  endfunction

  // Saturates a 27-bit signed value to 24 bits.
  // Clamping instead of wrapping keeps a full-scale sample from flipping its sign.
  // The limits are the largest and smallest 24-bit two's complement codes.
  function automatic logic [23:0] sat24(input logic signed [26:0] v);
    if (v > 27'sh07FFFFF) begin
      sat24 = 24'h7FFFFF;
    end else if (v < -27'sh0800000) begin
      sat24 = 24'h800000;
    end else begin
      sat24 = v[23:0];
    end
  endfunction

  // ----------------------------------------------------------------
  // Datapath.
  // ----------------------------------------------------------------
  sys_cal_pkg::bank_state_t state;        // Registered state.
  sys_cal_pkg::bank_state_t next_state;   // Next state.
  logic        [1:0]  sel;                // Selector of the incoming slot.
  logic signed [23:0] offset;             // Selected offset.
  logic        [23:0] gain;               // Selected gain.
  logic        use_system;                // System correction enabled.
  logic signed [25:0] diff;               // Sample minus offset.
  logic signed [50:0] prod;               // Offset-corrected sample times gain.
  logic signed [26:0] scaled;             // Gain-corrected and scaled result.

  // The offset is subtracted at full width first, then the gain is applied.
  // The unipolar doubling comes last, so the offset-corrected value is doubled, offset included.
  // Intermediate widths are chosen so that no step can wrap before saturation.
  // Picks the calibration set and forms the corrected result.
  always_comb begin
    sel = slot_sel(state.cal_set_select, conv_in.slot);
    case (sel)
      sys_cal_pkg::SEL_SET_A: begin
        offset     = signed'(state.system_offset_a);
        gain       = system_gain_a_in;
        use_system = 1'b1;
      end
      sys_cal_pkg::SEL_SET_B: begin
        offset     = signed'(system_offset_b_in);
        gain       = system_gain_b_in;
        use_system = 1'b1;
      end
      default: begin
        offset     = 24'sh000000;
        gain       = 24'h800000;
        use_system = 1'b0;
      end
    endcase
    // signed offset, subtraction after self-cal input
    diff = 26'(signed'(conv_in.sample)) - 26'(offset);
    prod = 51'(diff) * signed'({27'h0, gain});
    scaled = 27'(prod >>> sys_cal_pkg::GAIN_FRAC_BITS);
    if (conv_in.unipolar) begin
      scaled = scaled <<< 1;
    end
  end

  // Register writes and calibration loads take effect at the next clock edge.
  // The result strobe is cleared by default and raised only for a sample.
  // Builds the next register and output state.
  always_comb begin
    next_state = state;
    next_state.result_valid = 1'b0;
    if (reg_wr_in && reg_addr_in == sys_cal_pkg::CAL_SET_SELECT_ADDR) begin
      next_state.cal_set_select = reg_wdata_in & sys_cal_pkg::CAL_SET_SELECT_MASK;
    end
    if (cal_load_a_in) begin
      next_state.system_offset_a = cal_offset_a_in;
    end else if (reg_wr_in && reg_addr_in == sys_cal_pkg::SYSTEM_OFFSET_A_ADDR) begin
      next_state.system_offset_a = reg_wdata_in;
    end
    // Read data is latched on the strobe and holds until the next read.
    // An address outside the bank reads as zero rather than a stale value.
    if (reg_rd_in) begin
      case (reg_addr_in)
        sys_cal_pkg::CAL_SET_SELECT_ADDR:  next_state.rd_data = state.cal_set_select;
        sys_cal_pkg::SYSTEM_OFFSET_A_ADDR: next_state.rd_data = state.system_offset_a;
        default:                           next_state.rd_data = 24'h000000;
      endcase
    end
    // Corrected results are registered, so the strobe follows the sample by one cycle.
    // Bypass slots pass the sample untouched; their scale step is done elsewhere.
    if (conv_in.valid) begin
      next_state.result       = use_system ? sat24(scaled) : conv_in.sample;
      next_state.result_slot  = conv_in.slot;
      next_state.result_valid = 1'b1;
    end
  end

  // Registers the state.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state.cal_set_select  <= sys_cal_pkg::CAL_SET_SELECT_RESET;
      state.system_offset_a <= sys_cal_pkg::SYSTEM_OFFSET_RESET;
      state.rd_data         <= 24'h000000;
      state.result          <= 24'h000000;
      state.result_slot     <= 3'h0;
      state.result_valid    <= 1'b0;
    end else begin
      // The whole state moves as one word.
      state <= next_state;
    end
  end

  // Data outputs come straight from flip-flops.
  // Only the selector view is combinational, for the sample now presented.
  assign reg_rdata_out    = state.rd_data;
  assign result_out       = state.result;
  assign result_slot_out  = state.result_slot;
  assign result_valid_out = state.result_valid;
  assign slot_select_out  = sel;

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  // Checks on the selector, offset storage and correction datapath.
  // All are disabled while reset is applied.
  property p_unused_zero;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      (state.cal_set_select & ~sys_cal_pkg::CAL_SET_SELECT_MASK) == 24'h000000;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("Unused selector bits set.");

  property p_sel_write;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      reg_wr_in && reg_addr_in == sys_cal_pkg::CAL_SET_SELECT_ADDR
      |=> state.cal_set_select == ($past(reg_wdata_in) & sys_cal_pkg::CAL_SET_SELECT_MASK);
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("Selector write lost.");

  property p_off_hold;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      !cal_load_a_in && !(reg_wr_in && reg_addr_in == sys_cal_pkg::SYSTEM_OFFSET_A_ADDR)
      |=> $stable(state.system_offset_a);
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("Offset changed without write.");

  property p_off_cal;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      cal_load_a_in |=> state.system_offset_a == $past(cal_offset_a_in);
  endproperty
  a_off_cal: assert property (p_off_cal) else $error("Calibration load lost.");

  property p_bypass;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      conv_in.valid && sel[1] |=> result_valid_out && result_out == $past(conv_in.sample);
  endproperty
  a_bypass: assert property (p_bypass) else $error("Bypass slot was corrected.");

  property p_set_a_unity;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      conv_in.valid && sel == sys_cal_pkg::SEL_SET_A && state.system_offset_a == 24'h000000
      && system_gain_a_in == 24'h800000 && !conv_in.unipolar
      |=> result_out == $past(conv_in.sample);
  endproperty
  a_set_a_unity: assert property (p_set_a_unity) else $error("Set A unity path wrong.");

  property p_set_b_offset;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      conv_in.valid && sel == sys_cal_pkg::SEL_SET_B && conv_in.sample == 24'h000000
      && system_offset_b_in == 24'h000001 && system_gain_b_in == 24'h800000 && !conv_in.unipolar
      |=> result_out == 24'hFFFFFF;
  endproperty
  a_set_b_offset: assert property (p_set_b_offset) else $error("Set B offset not applied.");

  property p_strobe;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      conv_in.valid |=> result_valid_out && result_slot_out == $past(conv_in.slot);
  endproperty
  a_strobe: assert property (p_strobe) else $error("Result strobe missing.");

  // ----------------------------------------------------------------
  // Read path, hold and scale assertions.
  // ----------------------------------------------------------------
  // These guard the read data latch, the output hold between samples,
  // the reset values and the unipolar scale step.

  property p_read_sel;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      reg_rd_in && reg_addr_in == sys_cal_pkg::CAL_SET_SELECT_ADDR |=> reg_rdata_out == $past(state.cal_set_select);
  endproperty
  a_read_sel: assert property (p_read_sel) else $error("Selector read data wrong.");

  property p_read_off;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      reg_rd_in && reg_addr_in == sys_cal_pkg::SYSTEM_OFFSET_A_ADDR |=> reg_rdata_out == $past(state.system_offset_a);
  endproperty
  a_read_off: assert property (p_read_off) else $error("Offset read data wrong.");

  property p_read_unmapped;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      reg_rd_in && reg_addr_in != sys_cal_pkg::CAL_SET_SELECT_ADDR && reg_addr_in != sys_cal_pkg::SYSTEM_OFFSET_A_ADDR |=> reg_rdata_out == 24'h000000;
  endproperty
  a_read_unmapped: assert property (p_read_unmapped) else $error("Unmapped read not zero.");

  property p_off_write;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      reg_wr_in && reg_addr_in == sys_cal_pkg::SYSTEM_OFFSET_A_ADDR && !cal_load_a_in |=> state.system_offset_a == $past(reg_wdata_in);
  endproperty
  a_off_write: assert property (p_off_write) else $error("Offset write lost.");

  property p_rdata_hold;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      !reg_rd_in |=> $stable(reg_rdata_out);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("Read data changed without read.");

  property p_valid_pulse;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      !conv_in.valid |=> !result_valid_out;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("Spurious result strobe.");

  property p_result_hold;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      !conv_in.valid |=> $stable(result_out) && $stable(result_slot_out);
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("Result changed without sample.");

  property p_slot5;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      conv_in.slot == 3'h5 |-> slot_select_out == sys_cal_pkg::SEL_SET_A;
  endproperty
  a_slot5: assert property (p_slot5) else $error("Slot without field not set A.");

  property p_uni_double;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      conv_in.valid && sel == sys_cal_pkg::SEL_SET_A && state.system_offset_a == 24'h000000
      && system_gain_a_in == 24'h800000 && conv_in.unipolar && conv_in.sample == 24'h001000
      |=> result_out == 24'h002000;
  endproperty
  a_uni_double: assert property (p_uni_double) else $error("Unipolar scale wrong.");

  property p_reset_sel;
    @(posedge sys_clk_in)
      !reset_n_in |-> state.cal_set_select == sys_cal_pkg::CAL_SET_SELECT_RESET
      && state.system_offset_a == sys_cal_pkg::SYSTEM_OFFSET_RESET;
  endproperty
  a_reset_sel: assert property (p_reset_sel) else $error("Reset value wrong.");

  // Sample corrected with set A.
  c_set_a:  cover property (@(posedge sys_clk_in) conv_in.valid && sel == sys_cal_pkg::SEL_SET_A);
  // Sample corrected with set B.
  c_set_b:  cover property (@(posedge sys_clk_in) conv_in.valid && sel == sys_cal_pkg::SEL_SET_B);
  // Sample passed through uncorrected.
  c_bypass: cover property (@(posedge sys_clk_in) conv_in.valid && sel[1]);
  // Calibration load of the set A offset.
  c_cal:    cover property (@(posedge sys_clk_in) cal_load_a_in);
  // Corrected sample in unipolar scale.
  c_uni:    cover property (@(posedge sys_clk_in) conv_in.valid && conv_in.unipolar && !sel[1]);

endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the calibration selector, set A offset and correction datapath.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // Stimulus and observation signals.
  // ----------------------------------------------------------------
  logic                  sys_clk_in;          // Bench clock.
  logic                  reset_n_in;          // Reset, active low.
  logic                  reg_wr_in;           // Write strobe.
  logic                  reg_rd_in;           // Read strobe.
  logic [7:0]            reg_addr_in;         // Register address.
  logic [23:0]           reg_wdata_in;        // Write data.
  logic [23:0]           reg_rdata_out;       // Read data.
  logic                  cal_load_a_in;       // Calibration load pulse.
  logic [23:0]           cal_offset_a_in;     // Calibration offset value.
  logic [23:0]           system_offset_b_in;  // Set B offset.
  logic [23:0]           system_gain_a_in;    // Set A gain.
  logic [23:0]           system_gain_b_in;    // Set B gain.
  sys_cal_pkg::conv_in_t conv_in;             // Sample request.
  logic [23:0]           result_out;          // Corrected result.
  logic [2:0]            result_slot_out;     // Result slot.
  logic                  result_valid_out;    // Result strobe.
  logic [1:0]            slot_select_out;     // Selector in use.
  int                    n_errors;            // Mismatch count.
  int                    n_tests;             // Comparison count.
  int                    cycles;              // Watchdog count.
  logic [23:0]           off_a;               // Offset A the bench expects.
  logic [23:0]           smp [3];             // Sample table, includes saturating values.

  system_cal_select_offset uut (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .cal_load_a_in(cal_load_a_in), .cal_offset_a_in(cal_offset_a_in), .system_offset_b_in(system_offset_b_in),
    .system_gain_a_in(system_gain_a_in), .system_gain_b_in(system_gain_b_in), .conv_in(conv_in),
    .result_out(result_out), .result_slot_out(result_slot_out), .result_valid_out(result_valid_out),
    .slot_select_out(slot_select_out));

  // Clock generator, 100 ns period.
  initial begin
    sys_clk_in = 1'b0;
    forever #50 sys_clk_in = ~sys_clk_in;
  end

  // ----------------------------------------------------------------
  // Helpers.
  // ----------------------------------------------------------------
  // Compares a seen value with the expected one and reports a mismatch.
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Writes one register; an optional calibration load lands on the same edge.
  task automatic wr(input logic [7:0] a, input logic [23:0] d, input logic cal);
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b1; reg_addr_in <= a; reg_wdata_in <= d; cal_load_a_in <= cal;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0; cal_load_a_in <= 1'b0;
  endtask

  // Reads one register and returns the latched data once settled.
  task automatic rd(input logic [7:0] a, output logic [23:0] d);
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b1; reg_addr_in <= a;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    @(negedge sys_clk_in);
    d = reg_rdata_out;
  endtask

  // Expected corrected value: offset first, then gain, then the unipolar doubling, saturated.
  function automatic logic [23:0] model(input logic [23:0] s, o, g, input logic uni);
    longint p;
    p = ((longint'($signed(s)) - longint'($signed(o))) * longint'({40'h0, g})) >>> 23;
    if (uni) p = p * 2;
    if (p > 64'sd8388607) p = 64'sd8388607;
    if (p < -64'sd8388608) p = -64'sd8388608;
    return p[23:0];
  endfunction

  // Sends one sample and checks the selector, result, slot and strobe.
  task automatic send(input logic [2:0] sl, input logic uni, input logic [23:0] s, input logic [1:0] sel);
    logic [23:0] e;
    e = sel[1] ? s : (sel[0] ? model(s, system_offset_b_in, system_gain_b_in, uni)
                             : model(s, off_a, system_gain_a_in, uni));
    @(posedge sys_clk_in);
    conv_in <= '{valid: 1'b1, slot: sl, unipolar: uni, sample: s};
    @(negedge sys_clk_in);
    chk({22'h0, slot_select_out}, {22'h0, sel});                 // selector
    @(posedge sys_clk_in);
    conv_in.valid <= 1'b0;
    @(negedge sys_clk_in);
    chk({23'h0, result_valid_out}, 24'h000001);                  // strobe
    chk({21'h0, result_slot_out}, {21'h0, sl});                  // slot
    chk(result_out, e);                                          // result
  endtask

  // Watchdog against a hang.
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial begin
    logic [23:0] d;
    n_errors = 0; n_tests = 0; cycles = 0; off_a = 24'h000000;
    smp[0] = 24'h001000; smp[1] = 24'h7FFF00; smp[2] = 24'h900000;
    reset_n_in = 1'b0; reg_wr_in = 1'b0; reg_rd_in = 1'b0; reg_addr_in = 8'h00; reg_wdata_in = 24'h000000;
    cal_load_a_in = 1'b0; cal_offset_a_in = 24'hABCDEF; system_offset_b_in = 24'h000010;
    system_gain_a_in = 24'h800000; system_gain_b_in = 24'h400000; conv_in = '0;
    repeat (20) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    rd(8'h12, d); chk(d, 24'h000000);                            // reset
    rd(8'h13, d); chk(d, 24'h000000);                            // reset
    // Unity set A path in both scales, with the offset still at reset.
    send(3'd0, 1'b0, smp[0], 2'h0);                              // unity
    send(3'd0, 1'b1, smp[0], 2'h0);                              // doubling
    off_a = 24'hFFFF00;
    wr(8'h12, 24'hFFFFFF, 1'b0); rd(8'h12, d); chk(d, 24'h00F3FF); // mask
    wr(8'h12, 24'hFF6DE4, 1'b0); rd(8'h12, d); chk(d, 24'h0061E4); // fields
    wr(8'h13, off_a, 1'b0); rd(8'h13, d); chk(d, off_a);         // rw
    wr(8'h14, 24'h555555, 1'b0); rd(8'h13, d); chk(d, off_a);    // unmapped write
    rd(8'h20, d); chk(d, 24'h000000);                            // unmapped read
    // Every slot, both scale modes, every sample.
    for (int i = 0; i < 8; i++)
      for (int u = 0; u < 2; u++)
        for (int k = 0; k < 3; k++)
          send(i[2:0], u[0], smp[k], 16'h61E4 >> (2 * i));
    // Calibration load beats a same-edge software write.
    wr(8'h13, 24'h111111, 1'b1); off_a = 24'hABCDEF;
    rd(8'h13, d); chk(d, off_a);                                 // cal load
    send(3'd0, 1'b1, smp[0], 2'h0);                              // new offset
    // Set B offset of one on a zero sample at unity gain.
    @(posedge sys_clk_in);
    system_offset_b_in <= 24'h000001; system_gain_b_in <= 24'h800000;
    @(negedge sys_clk_in);
    send(3'd1, 1'b0, 24'h000000, 2'h1);                          // set B offset
    complete_run();
  end
endmodule
